// [logic/pls_pkg.sv]
/*
 Package for the periodic-start and low-speed threshold block:
 register offsets, field widths, reset values and scheduler states.
 Assumes a byte-addressed register port relative to the controller base address.
*/
`default_nettype none

package pls_pkg;

    // Register port geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register offsets from the base address
    localparam logic [7:0] OFS_PERIODIC_PRIORITY_START = 8'h40;
    localparam logic [7:0] OFS_LOWSPEED_COMMIT_THRESHOLD = 8'h44;

    // Periodic-start field, bits 13 to 0
    localparam int unsigned PS_W = 14;
    localparam int unsigned PS_LSB = 0;
    localparam logic [13:0] PS_RESET = 14'h0000;

    // Low-speed threshold field, bits 11 to 0
    localparam int unsigned THR_W = 12;
    localparam int unsigned THR_LSB = 0;
    localparam logic [11:0] THR_RESET = 12'h628;

    // Frame-remaining count width
    localparam int unsigned REMAIN_W = 14;

    // Read data for unmapped offsets
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

    typedef enum logic [1:0] {
        PLS_ST_NONPERIODIC,
        PLS_ST_DRAIN,
        PLS_ST_PERIODIC
    } pls_sched_e;

endpackage : pls_pkg

`default_nettype wire

// [logic/pls_ls_gate.sv]
/*
 Low-speed commit gate: decides whether a pending low-speed transaction
 may start in the current frame, or must wait for the next one.
 Assumes frame-remaining count and frame start come from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pls_ls_gate (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic frame_start_in,
    input wire logic ls_request_in,
    input wire logic [13:0] frame_remaining_count_in,
    input wire logic [11:0] lowspeed_threshold_value_in,
    output logic ls_start_out,
    output logic ls_deferred_out
);

    logic start_ff;
    logic deferred_ff;
    logic remain_ge_thr;
    logic nxt_start;
    logic nxt_deferred;

    assign remain_ge_thr = frame_remaining_count_in >= {2'b00, lowspeed_threshold_value_in};

    assign nxt_start = ls_request_in & remain_ge_thr & ~deferred_ff & ~start_ff;

    // defer refused request to next frame; set wins over frame clear
    assign nxt_deferred = (ls_request_in & ~remain_ge_thr) | (deferred_ff & ~frame_start_in);

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            start_ff <= 1'b0;
            deferred_ff <= 1'b0;
        end else begin
            start_ff <= nxt_start;
            deferred_ff <= nxt_deferred;
        end
    end

    assign ls_start_out = start_ff;
    assign ls_deferred_out = deferred_ff;

    AST_LS_START_NEEDS_TIME: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $rose(ls_start_out) |-> $past(remain_ge_thr) && $past(ls_request_in))
        else $error("low-speed start without enough frame time");

    AST_LS_REFUSED: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (ls_request_in && !remain_ge_thr) |=> (!ls_start_out && ls_deferred_out))
        else $error("short frame did not refuse low-speed start");

    AST_LS_DEFER_HELD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (ls_deferred_out && !frame_start_in) |=> (ls_deferred_out && !ls_start_out))
        else $error("deferred low-speed request released inside frame");

endmodule // pls_ls_gate

`default_nettype wire

// [logic/pls_top.sv]
/*
 Frame-scheduling threshold block: holds the periodic-start and low-speed
 threshold registers, hands priority to periodic lists late in the frame,
 and gates low-speed transaction starts.
 Assumes register port, frame counter and list engine share clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Periodic start bits 13:0, reset zero
// - Reaching periodic start gives periodic priority
// - Finish current transaction, then interrupt list
// - Twelve-bit threshold guards eight-byte low-speed
// - Compare remaining count before low-speed start
// - Start low-speed only if remaining >= threshold
// - Hardware never alters low-speed threshold
module pls_top (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Register port, offsets from base address
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    // Frame timing from the frame counter
    input wire logic frame_start_in,
    input wire logic [13:0] frame_remaining_count_in,
    // List engine handshake
    input wire logic xfer_busy_in,
    input wire logic ls_request_in,
    output logic periodic_prio_out,
    output logic periodic_go_out,
    output logic nonperiodic_allow_out,
    output logic ls_start_out,
    output logic ls_deferred_out
);

    logic [13:0] start_ff;
    logic [11:0] thr_ff;
    logic [31:0] rdata_ff;
    pls_pkg::pls_sched_e state_ff;
    pls_pkg::pls_sched_e nxt_state;

    logic sel_ps;
    logic sel_thr;
    logic wr_ps;
    logic wr_thr;
    logic start_reached;
    logic [13:0] nxt_start;
    logic [11:0] nxt_thr;
    logic [31:0] rd_mux;

    // Register decode
    assign sel_ps = reg_addr_in == pls_pkg::OFS_PERIODIC_PRIORITY_START;
    assign sel_thr = reg_addr_in == pls_pkg::OFS_LOWSPEED_COMMIT_THRESHOLD;
    assign wr_ps = reg_wr_in & sel_ps;
    assign wr_thr = reg_wr_in & sel_thr;

    assign nxt_start = wr_ps ? reg_wdata_in[pls_pkg::PS_LSB +: pls_pkg::PS_W] : start_ff;

    // only a software write moves it
    assign nxt_thr = wr_thr ? reg_wdata_in[pls_pkg::THR_LSB +: pls_pkg::THR_W] : thr_ff;

    // Reserved bits read as zero; unmapped offsets read zero
    assign rd_mux = sel_ps ? {18'h00000, start_ff} :
                    sel_thr ? {20'h00000, thr_ff} :
                    pls_pkg::RDATA_UNMAPPED;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            start_ff <= pls_pkg::PS_RESET;
            thr_ff <= pls_pkg::THR_RESET;
            rdata_ff <= 32'h0000_0000;
        end else begin
            start_ff <= nxt_start;
            thr_ff <= nxt_thr;
            if (reg_rd_in) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    assign reg_rdata_out = rdata_ff;

    assign start_reached = frame_remaining_count_in <= start_ff;

    // Priority returns to control/bulk at every new frame
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pls_pkg::PLS_ST_NONPERIODIC: begin
                if (start_reached) begin
                    nxt_state = xfer_busy_in ? pls_pkg::PLS_ST_DRAIN : pls_pkg::PLS_ST_PERIODIC;
                end
            end
            pls_pkg::PLS_ST_DRAIN: begin
                if (!xfer_busy_in) begin
                    nxt_state = pls_pkg::PLS_ST_PERIODIC;
                end
            end
            pls_pkg::PLS_ST_PERIODIC: begin
                nxt_state = pls_pkg::PLS_ST_PERIODIC;
            end
            default: begin
                nxt_state = pls_pkg::PLS_ST_NONPERIODIC;
            end
        endcase
        if (frame_start_in) begin
            nxt_state = pls_pkg::PLS_ST_NONPERIODIC;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= pls_pkg::PLS_ST_NONPERIODIC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign periodic_prio_out = state_ff != pls_pkg::PLS_ST_NONPERIODIC;
    assign periodic_go_out = state_ff == pls_pkg::PLS_ST_PERIODIC;
    assign nonperiodic_allow_out = state_ff == pls_pkg::PLS_ST_NONPERIODIC;

    pls_ls_gate u_ls_gate (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .frame_start_in(frame_start_in),
        .ls_request_in(ls_request_in),
        .frame_remaining_count_in(frame_remaining_count_in),
        .lowspeed_threshold_value_in(thr_ff),
        .ls_start_out(ls_start_out),
        .ls_deferred_out(ls_deferred_out)
    );

    AST_PS_RESET_ZERO: assert property (@(posedge clk_sys_in)
        $rose(rst_b_in) |-> (start_ff == 14'h0000))
        else $error("periodic start not zero after reset");

    AST_RESERVED_READ_ZERO: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(reg_rd_in && (sel_ps || sel_thr)) |-> (reg_rdata_out[31:14] == 18'h00000))
        else $error("reserved bits read nonzero");

    AST_THR_WIDTH: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $past(reg_rd_in && sel_thr) |-> (reg_rdata_out[31:12] == 20'h00000 && reg_rdata_out[11:0] == $past(thr_ff)))
        else $error("threshold read wrong");

    AST_THR_STABLE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !wr_thr |=> $stable(thr_ff))
        else $error("threshold changed without software write");

    AST_PRIO_ENTER: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (nonperiodic_allow_out && start_reached && !frame_start_in) |=> periodic_prio_out)
        else $error("periodic priority not taken at periodic start");

    AST_DRAIN_WAIT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (state_ff == pls_pkg::PLS_ST_DRAIN && xfer_busy_in && !frame_start_in) |=> (state_ff == pls_pkg::PLS_ST_DRAIN))
        else $error("periodic began before transaction finished");

    AST_GO_AFTER_IDLE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $rose(periodic_go_out) |-> $past(!xfer_busy_in) && $past(start_reached || periodic_prio_out))
        else $error("interrupt list started while busy");

    AST_FRAME_RESTORE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        frame_start_in |=> nonperiodic_allow_out)
        else $error("new frame kept periodic priority");

    AST_PS_WRITE_LANDS: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        wr_ps |=> (start_ff == $past(reg_wdata_in[13:0])))
        else $error("periodic start write lost");

    AST_PS_ONLY_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !wr_ps |=> $stable(start_ff))
        else $error("periodic start changed without write");

    AST_THR_WRITE_LANDS: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        wr_thr |=> (thr_ff == $past(reg_wdata_in[11:0])))
        else $error("threshold write lost");

    AST_UNMAPPED_READ_ZERO: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (reg_rd_in && !sel_ps && !sel_thr) |=> (reg_rdata_out == pls_pkg::RDATA_UNMAPPED))
        else $error("unmapped offset read nonzero");

    AST_RDATA_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data changed without read");

    AST_NO_EARLY_PRIO: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (nonperiodic_allow_out && !start_reached) |=> nonperiodic_allow_out)
        else $error("periodic priority taken before periodic start");

    AST_PRIO_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (periodic_prio_out && !frame_start_in) |=> periodic_prio_out)
        else $error("periodic priority dropped inside frame");

    AST_DRAIN_ENTRY: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (nonperiodic_allow_out && start_reached && xfer_busy_in && !frame_start_in)
            |=> (periodic_prio_out && !periodic_go_out))
        else $error("busy transaction not drained first");

    AST_DRAIN_EXIT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (state_ff == pls_pkg::PLS_ST_DRAIN && !xfer_busy_in && !frame_start_in) |=> periodic_go_out)
        else $error("interrupt list not started after drain");

    AST_DIRECT_GO: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (nonperiodic_allow_out && start_reached && !xfer_busy_in && !frame_start_in) |=> periodic_go_out)
        else $error("idle controller did not start interrupt list");

    AST_GO_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (periodic_go_out && !frame_start_in) |=> periodic_go_out)
        else $error("periodic processing dropped inside frame");

endmodule // pls_top

`default_nettype wire

// [test/pls_top_tb_top.sv]
/*
 Self-checking bench for pls_top: register access, priority hand-over, low-speed gate.
 Assumes one 25 MHz clock and read data registered one cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module pls_top_tb_top;
    // Driver-side choices, plain defaults: frame length and low-speed cost
    localparam int FRAME_IVL = 12000;
    localparam int LS_XMIT = 1500;
    localparam int LS_SETUP = 76;
    localparam int TYPICAL_PS = 32'h0000_3E67;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic fs = 1'b0;
    logic [13:0] remain = 14'h3FFF;
    logic busy = 1'b0;
    logic lsreq = 1'b0;
    logic prio, go, allow, lss, lsd;
    int n_mismatch = 0;
    int checked = 0;
    logic [31:0] rng = 32'h0000_0062;
    int ps_m = 0;
    int thr_m = 32'h0000_0628;

    always #20 clk_sys_in = ~clk_sys_in;

    pls_top dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .frame_start_in(fs),
        .frame_remaining_count_in(remain), .xfer_busy_in(busy), .ls_request_in(lsreq),
        .periodic_prio_out(prio), .periodic_go_out(go), .nonperiodic_allow_out(allow),
        .ls_start_out(lss), .ls_deferred_out(lsd));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic close_out;
        $display("checked=%0d mismatches=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        @(negedge clk_sys_in);
        chk(rdata, e);
    endtask

    task automatic pulse_fs;
        @(posedge clk_sys_in);
        fs <= 1'b1;
        remain <= 14'h3FFF;
        @(posedge clk_sys_in);
        fs <= 1'b0;
        @(negedge clk_sys_in);
    endtask

    // Bounded wait: the go level must follow within a few cycles
    task automatic wait_go;
        for (int k = 0; k < 4 && go !== 1'b1; k++) @(negedge clk_sys_in);
        chk(go, 1'b1);
        if (go !== 1'b1) close_out();
    endtask

    task automatic ls_try(input logic [13:0] f);
        logic e;
        e = (int'(f) >= thr_m);
        @(posedge clk_sys_in);
        remain <= f;
        lsreq <= 1'b1;
        @(posedge clk_sys_in);
        lsreq <= 1'b0;
        @(negedge clk_sys_in);
        chk(lss, e);
        chk(lsd, !e);
        @(negedge clk_sys_in);
        chk(lss, 1'b0);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        rd_reg(8'h40, 32'h0000_0000);
        rd_reg(8'h44, 32'h0000_0628);
        rd_reg(8'h48, 32'h0000_0000);
        chk(allow, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            ps_m = int'(rng[13:0]);
            wr_reg(8'h40, rng & 32'h0000_3FFF);
            rd_reg(8'h40, ps_m);
            rng = xs(rng);
            thr_m = int'(rng[11:0]);
            wr_reg(8'h44, rng & 32'h0000_0FFF);
            rd_reg(8'h44, thr_m);
        end
        wr_reg(8'h48, 32'hFFFF_FFFF);
        rd_reg(8'h40, ps_m);
        rd_reg(8'h44, thr_m);
        wr_reg(8'h40, TYPICAL_PS);
        rd_reg(8'h40, TYPICAL_PS);
        ps_m = FRAME_IVL / 10;
        wr_reg(8'h40, ps_m);
        thr_m = LS_XMIT + LS_SETUP;
        wr_reg(8'h44, thr_m);
        rd_reg(8'h44, thr_m);
        // Clear any priority left by the random start values
        pulse_fs();
        $display("test registers done");
        @(posedge clk_sys_in);
        remain <= 14'(ps_m + 1);
        busy <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk(prio, 1'b0);
        @(posedge clk_sys_in);
        remain <= 14'(ps_m);
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk(prio, 1'b1);
        chk(allow, 1'b0);
        chk(go, 1'b0);
        @(posedge clk_sys_in);
        busy <= 1'b0;
        wait_go();
        pulse_fs();
        chk({prio, go, allow}, 3'b001);
        @(posedge clk_sys_in);
        remain <= 14'h0050;
        wait_go();
        pulse_fs();
        $display("test priority done");
        ls_try(14'(thr_m + 1));
        ls_try(14'(thr_m));
        ls_try(14'(thr_m - 1));
        @(posedge clk_sys_in);
        remain <= 14'h3FFF;
        lsreq <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        lsreq <= 1'b0;
        @(negedge clk_sys_in);
        chk({lss, lsd}, 2'b01);
        pulse_fs();
        chk(lsd, 1'b0);
        ls_try(14'h3FFF);
        // Request held across the frame boundary is served in the next frame
        ls_try(14'(thr_m - 1));
        @(posedge clk_sys_in);
        remain <= 14'h3FFF;
        lsreq <= 1'b1;
        pulse_fs();
        chk({lss, lsd}, 2'b00);
        @(posedge clk_sys_in);
        lsreq <= 1'b0;
        @(negedge clk_sys_in);
        chk(lss, 1'b1);
        @(negedge clk_sys_in);
        chk(lss, 1'b0);
        rd_reg(8'h44, thr_m);
        $display("test low-speed done");
        close_out();
    end
endmodule // pls_top_tb_top
`default_nettype wire
